// [rtl/rsh_device.sv]
// Remote panel station end: link bit mapping, handshake flags, word access.
//
// Function
// - Area base configurable within words 20 to 1980.
// - Ordinary mode refuses system and relay areas.
// - Command mode bits map to user bits.
// - Command mode words reach user or system.
// - Command mode blocks user writes, denies relay.
// - User bits sized 48, 80, 112 points.
// - Status word: done, touch, tag, init, error, ready.
// - Request word: display, monitor, periodic, init, reset.
// - Base word m is (station - 1) times 2.
// - Offset n is 3, 5 or 7.
// - Display done follows finish, cleared with request.
// - Word 13 write sets touch, tag; read clears.
// - Init done answers init request.
// - Init request and done both return off.
// - Error set on system area command error in command mode.
// - Ready only when online and linked.
// - Ready off when offline or loading.
// - Error reset request clears error flag.
// - Speed code 0 to 4 for 156k to 10M.
// - Station 1 to 63, 62 or 61 capped.
// - Monitor request in command mode returns registered system entries.
`timescale 1ns/1ps
module rsh_device
  import rsh_pkg::*;
(
  input wire logic clk, // 20 MHz system clock
  input wire logic rst, // synchronous reset, leaving online mode
  rsh_link_if.dev link, // cyclic link to the master
  input wire logic [5:0] stationNo, // station number
  input wire logic [2:0] occNodes, // occupied node count
  input wire logic cmdMode, // 1 command monitoring, 0 ordinary
  input wire logic [10:0] systemAreaBase, // start word of link areas
  input wire logic [2:0] linkSpeed, // speed code
  input wire logic online, // panel is in online mode
  input wire logic linkDone, // data linking completed
  input wire logic initLoading, // initial data being received
  input wire logic procDone, // panel finished requested processing
  input wire logic tagWrite, // panel writes system word 13
  input wire logic [15:0] tagData, // value written to word 13
  input wire logic [USER_BITS-1:0] rxUserIn, // panel user bits out
  output logic [USER_BITS-1:0] ryUserOut, // user bits from master
  output logic [6:0] mBase, // base bit word index
  output logic [2:0] nOffset, // offset to system bit word
  output logic [6:0] userPoints, // user bits per direction
  output logic cfgValid // settings are legal
);

  typedef struct packed {
    logic [15:0] rx;
    logic [USER_BITS-1:0] rxUser;
    logic [USER_BITS-1:0] ryUser;
    logic [6:0] mBase;
    logic [2:0] nOff;
    logic [6:0] points;
    logic cfgOk;
    logic rspValid;
    logic rspErr;
    logic [15:0] rspData;
    logic monValid;
    logic [1:0] monIdx;
    logic [15:0] monData;
    logic [UA_WORDS-1:0][15:0] userMem;
    logic [SA_WORDS-1:0][15:0] sysMem;
  } rsh_dev_st_t;

  rsh_dev_st_t st_q;
  rsh_dev_st_t st_d;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [15:0] ry;
    logic [10:0] uIdx;
    logic [USER_BITS-1:0] mask;
    logic okCmd;
    logic sysErr;
    logic tagRead;
    logic finish;
    logic readyNow;
    st_d = st_q;
    ry = link.ryWord & RY_USED_MASK;
    uIdx = link.cmdAddr - systemAreaBase;
    mask = '0;
    okCmd = 1'b0;
    sysErr = 1'b0;
    tagRead = 1'b0;
    finish = 1'b0;
    readyNow = 1'b0;

    st_d.cfgOk = (occNodes >= 3'h2) && (occNodes <= 3'h4)
      && (stationNo != 6'h00)
      && (stationNo <= rsh_station_max(occNodes))
      && (systemAreaBase >= BASE_MIN) && (systemAreaBase <= BASE_MAX)
      && (linkSpeed <= 3'(SPD_10M));
    st_d.mBase = rsh_m_base(stationNo);
    st_d.nOff = rsh_n_off(occNodes);
    st_d.points = rsh_points(occNodes);
    for (int i = 0; i < USER_BITS; i++) begin
      mask[i] = (7'(i) < st_q.points) && st_q.cfgOk;
    end
    // bits map straight to user area in both modes
    st_d.rxUser = rxUserIn & mask;
    st_d.ryUser = link.ryUser & mask;

    // Word commands answer one cycle later, always.
    st_d.rspValid = link.cmdValid;
    st_d.rspErr = 1'b0;
    st_d.rspData = 16'h0000;
    if (link.cmdValid) begin
      if (link.cmdSys) begin
        // system area only in command mode
        okCmd = cmdMode && (link.cmdAddr < 11'(RELAY_BASE));
        sysErr = !okCmd && cmdMode;
        if (okCmd && link.cmdWrite) begin
          st_d.sysMem[link.cmdAddr[4:0]] = link.cmdData;
        end else if (okCmd) begin
          st_d.rspData = st_q.sysMem[link.cmdAddr[4:0]];
          tagRead = link.cmdAddr == TAG_WORD;
        end
      end else begin
        // user writes blocked in command mode
        okCmd = (uIdx < 11'(UA_WORDS)) && !(cmdMode && link.cmdWrite);
        if (okCmd && link.cmdWrite) begin
          st_d.userMem[uIdx[3:0]] = link.cmdData;
        end else if (okCmd) begin
          st_d.rspData = st_q.userMem[uIdx[3:0]];
        end
      end
      st_d.rspErr = !okCmd;
      finish = okCmd;
    end
    if (tagWrite) begin
      st_d.sysMem[TAG_WORD[4:0]] = tagData;
    end

    st_d.rx = st_q.rx & 16'h0EA1;
    // display done set on finish, dropped with request
    if (!ry[RY_DISP_REQ]) begin
      st_d.rx[RX_DISP_DONE] = 1'b0;
    end else if (finish || procDone) begin
      st_d.rx[RX_DISP_DONE] = 1'b1;
    end
    // word 13 handshake, a new write beats the read
    if (tagWrite) begin
      st_d.rx[RX_TOUCH_DONE] = 1'b1;
      st_d.rx[RX_TAG_REQ] = 1'b1;
    end else if (tagRead) begin
      st_d.rx[RX_TOUCH_DONE] = 1'b0;
      st_d.rx[RX_TAG_REQ] = 1'b0;
    end
    st_d.rx[RX_INIT_DONE] = ry[RY_INIT_REQ];
    // error sticky, set wins over reset
    if (sysErr) begin
      st_d.rx[RX_ERROR] = 1'b1;
    end else if (ry[RY_ERR_RST]) begin
      st_d.rx[RX_ERROR] = 1'b0;
    end
    // ready from online, linked, not loading and legal settings
    readyNow = online && linkDone && !initLoading && st_q.cfgOk;
    st_d.rx[RX_READY] = readyNow;

    st_d.monValid = ry[RY_MON_REQ] && cmdMode;
    if (ry[RY_MON_REQ] && cmdMode) begin
      st_d.monIdx = st_q.monIdx + 2'h1;
      st_d.monData = st_q.sysMem[st_q.monIdx];
    end else begin
      st_d.monIdx = 2'h0;
      st_d.monData = 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign link.rxWord = st_q.rx;
  assign link.rxUser = st_q.rxUser;
  assign link.rspValid = st_q.rspValid;
  assign link.rspErr = st_q.rspErr;
  assign link.rspData = st_q.rspData;
  assign link.monValid = st_q.monValid;
  assign link.monIdx = st_q.monIdx;
  assign link.monData = st_q.monData;
  assign ryUserOut = st_q.ryUser;
  assign mBase = st_q.mBase;
  assign nOffset = st_q.nOff;
  assign userPoints = st_q.points;
  assign cfgValid = st_q.cfgOk;

endmodule

// [rtl/rsh_pkg.sv]
// Shared constants, types and helpers for the remote station handshake.
package rsh_pkg;

  // ----------------------------------------------------------------
  // Link geometry
  // ----------------------------------------------------------------
  localparam int USER_BITS = 112;
  localparam int UA_WORDS = 16;
  localparam int SA_WORDS = 32;
  localparam int RELAY_BASE = 24;
  localparam int MON_ENTRIES = 4;
  localparam logic [10:0] TAG_WORD = 11'h00D;
  localparam logic [10:0] BASE_MIN = 11'h014;
  localparam logic [10:0] BASE_MAX = 11'h7BC;
  localparam logic [5:0] STATION_MAX2 = 6'h3F;
  localparam logic [5:0] STATION_MAX3 = 6'h3E;
  localparam logic [5:0] STATION_MAX4 = 6'h3D;
  localparam logic [6:0] M_STEP = 7'h02;
  localparam logic [6:0] POINTS2 = 7'h30;
  localparam logic [6:0] POINTS3 = 7'h50;
  localparam logic [6:0] POINTS4 = 7'h70;
  localparam logic [2:0] N_OFF2 = 3'h3;
  localparam logic [2:0] N_OFF3 = 3'h5;
  localparam logic [2:0] N_OFF4 = 3'h7;

  // ----------------------------------------------------------------
  // System bit word layout
  // ----------------------------------------------------------------
  localparam int RX_DISP_DONE = 0;
  localparam int RX_TOUCH_DONE = 5;
  localparam int RX_TAG_REQ = 7;
  localparam int RX_INIT_DONE = 9;
  localparam int RX_ERROR = 10;
  localparam int RX_READY = 11;
  localparam int RY_DISP_REQ = 0;
  localparam int RY_MON_REQ = 1;
  localparam int RY_PER_REQ = 2;
  localparam int RY_INIT_REQ = 9;
  localparam int RY_ERR_RST = 10;
  localparam logic [15:0] RY_USED_MASK = 16'h0607;

  // ----------------------------------------------------------------
  // Master register map and command word fields
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_CFG = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h2;
  localparam logic [3:0] REG_CMD = 4'h3;
  localparam logic [3:0] REG_WDATA = 4'h4;
  localparam logic [3:0] REG_RESULT = 4'h5;
  localparam logic [3:0] REG_CMDST = 4'h6;
  localparam logic [3:0] REG_AUTO = 4'h7;
  localparam logic [3:0] REG_TAG = 4'h8;
  localparam logic [3:0] REG_MAP = 4'h9;
  localparam logic [3:0] REG_MON = 4'hA;
  localparam int CMD_WRITE_BIT = 15;
  localparam int CMD_SYS_BIT = 14;
  localparam logic [15:0] CFG_RESET = 16'h0201;

  typedef enum logic [2:0] {
    SPD_156K = 3'h0,
    SPD_625K = 3'h1,
    SPD_2M5 = 3'h2,
    SPD_5M = 3'h3,
    SPD_10M = 3'h4
  } rsh_speed_t;

  function automatic logic [6:0] rsh_m_base(input logic [5:0] station);
    rsh_m_base = 7'({1'b0, station} - 7'h01) * M_STEP;
  endfunction

  function automatic logic [2:0] rsh_n_off(input logic [2:0] occ);
    case (occ)
      3'h3: rsh_n_off = N_OFF3;
      3'h4: rsh_n_off = N_OFF4;
      default: rsh_n_off = N_OFF2;
    endcase
  endfunction

  function automatic logic [6:0] rsh_points(input logic [2:0] occ);
    case (occ)
      3'h3: rsh_points = POINTS3;
      3'h4: rsh_points = POINTS4;
      default: rsh_points = POINTS2;
    endcase
  endfunction

  function automatic logic [5:0] rsh_station_max(input logic [2:0] occ);
    case (occ)
      3'h3: rsh_station_max = STATION_MAX3;
      3'h4: rsh_station_max = STATION_MAX4;
      default: rsh_station_max = STATION_MAX2;
    endcase
  endfunction

endpackage

// [rtl/rsh_link_if.sv]
// Cyclic link between the master station and the remote panel station.
`timescale 1ns/1ps
interface rsh_link_if;
  import rsh_pkg::*;
  logic [15:0] ryWord;
  logic [15:0] rxWord;
  logic [USER_BITS-1:0] ryUser;
  logic [USER_BITS-1:0] rxUser;
  logic cmdValid;
  logic cmdWrite;
  logic cmdSys;
  logic [10:0] cmdAddr;
  logic [15:0] cmdData;
  logic rspValid;
  logic rspErr;
  logic [15:0] rspData;
  logic monValid;
  logic [1:0] monIdx;
  logic [15:0] monData;

  modport dev (
    input ryWord, ryUser, cmdValid, cmdWrite, cmdSys, cmdAddr, cmdData,
    output rxWord, rxUser, rspValid, rspErr, rspData, monValid, monIdx,
    output monData
  );
  modport mst (
    output ryWord, ryUser, cmdValid, cmdWrite, cmdSys, cmdAddr, cmdData,
    input rxWord, rxUser, rspValid, rspErr, rspData, monValid, monIdx,
    input monData
  );
endinterface

// [rtl/rsh_master.sv]
// Master station end: request flags, word commands and tag code polling.
`timescale 1ns/1ps
module rsh_master
  import rsh_pkg::*;
(
  input wire logic clk, // 20 MHz system clock
  input wire logic rst, // synchronous reset
  rsh_link_if.mst link, // cyclic link to the panel
  input wire logic [3:0] regAddr, // register index
  input wire logic [15:0] regWdata, // write data
  input wire logic regWr, // write strobe
  input wire logic regRd, // read strobe
  output logic [15:0] regRdata, // read data, cycle after strobe
  input wire logic [USER_BITS-1:0] ryUserIn, // user bits to panel
  output logic [USER_BITS-1:0] rxUserOut // user bits from panel
);

  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] cfg;
    logic [15:0] wdata;
    logic [15:0] result;
    logic busy;
    logic done;
    logic err;
    logic autoEn;
    logic [15:0] tag;
    logic [15:0] mon;
    logic autoPend;
    logic cmdValid;
    logic cmdWrite;
    logic cmdSys;
    logic [10:0] cmdAddr;
    logic [15:0] cmdData;
    logic [USER_BITS-1:0] ryUser;
    logic [USER_BITS-1:0] rxUser;
    logic [15:0] rdata;
  } rsh_mst_st_t;

  rsh_mst_st_t st_q;
  rsh_mst_st_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.cmdValid = 1'b0;
    st_d.ryUser = ryUserIn;
    st_d.rxUser = link.rxUser;
    st_d.rdata = 16'h0000;
    if (link.monValid) begin
      st_d.mon = link.monData;
    end
    if (link.rspValid) begin
      st_d.busy = 1'b0;
      st_d.done = 1'b1;
      st_d.err = link.rspErr;
      st_d.result = link.rspData;
      if (st_q.autoPend) begin
        st_d.tag = link.rspData;
        st_d.autoPend = 1'b0;
      end
    end
    if (regWr) begin
      unique case (regAddr)
        REG_CTRL: st_d.ctrl = regWdata & RY_USED_MASK;
        REG_CFG: st_d.cfg = regWdata;
        REG_WDATA: st_d.wdata = regWdata;
        REG_AUTO: st_d.autoEn = regWdata[0];
        REG_CMD: begin
          if (!st_q.busy) begin
            st_d.cmdValid = 1'b1;
            st_d.cmdWrite = regWdata[CMD_WRITE_BIT];
            st_d.cmdSys = regWdata[CMD_SYS_BIT];
            st_d.cmdAddr = regWdata[10:0];
            st_d.cmdData = st_q.wdata;
            st_d.busy = 1'b1;
            st_d.done = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // continuous read of word 13 while touch flag stands
    if (!st_d.cmdValid && !st_q.busy && st_q.autoEn
        && link.rxWord[RX_TOUCH_DONE]) begin
      st_d.cmdValid = 1'b1;
      st_d.cmdWrite = 1'b0;
      st_d.cmdSys = 1'b1;
      st_d.cmdAddr = TAG_WORD;
      st_d.busy = 1'b1;
      st_d.autoPend = 1'b1;
    end
    // init request dropped once done is seen
    if (st_q.ctrl[RY_INIT_REQ] && link.rxWord[RX_INIT_DONE]) begin
      st_d.ctrl[RY_INIT_REQ] = 1'b0;
    end
    // error reset request dropped once error clears
    if (st_q.ctrl[RY_ERR_RST] && !link.rxWord[RX_ERROR]) begin
      st_d.ctrl[RY_ERR_RST] = 1'b0;
    end
    if (regRd) begin
      unique case (regAddr)
        REG_CTRL: st_d.rdata = st_q.ctrl;
        REG_CFG: st_d.rdata = st_q.cfg;
        REG_STATUS: st_d.rdata = link.rxWord;
        REG_WDATA: st_d.rdata = st_q.wdata;
        REG_RESULT: st_d.rdata = st_q.result;
        REG_CMDST: st_d.rdata = {13'h0000, st_q.err, st_q.done, st_q.busy};
        REG_AUTO: st_d.rdata = {15'h0000, st_q.autoEn};
        REG_TAG: st_d.rdata = st_q.tag;
        // placement seen from the master side
        REG_MAP: st_d.rdata = {6'h00, rsh_n_off(st_q.cfg[10:8]),
                               rsh_m_base(st_q.cfg[5:0])};
        REG_MON: st_d.rdata = st_q.mon;
        default: st_d.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
      st_q.cfg <= CFG_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign link.ryWord = st_q.ctrl;
  assign link.ryUser = st_q.ryUser;
  assign link.cmdValid = st_q.cmdValid;
  assign link.cmdWrite = st_q.cmdWrite;
  assign link.cmdSys = st_q.cmdSys;
  assign link.cmdAddr = st_q.cmdAddr;
  assign link.cmdData = st_q.cmdData;
  assign regRdata = st_q.rdata;
  assign rxUserOut = st_q.rxUser;

endmodule

// [dv/rsh_sva.sv]
// Concurrent checks on the link between the master and the panel station.
`timescale 1ns/1ps
module rsh_sva
  import rsh_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst, // synchronous reset
  input wire logic [15:0] ryWord, // request word
  input wire logic [15:0] rxWord, // status word
  input wire logic cmdValid, // command pulse
  input wire logic cmdWrite, // command is a write
  input wire logic cmdSys, // command targets system area
  input wire logic [10:0] cmdAddr, // command word address
  input wire logic rspValid, // response pulse
  input wire logic rspErr, // response refused
  input wire logic [15:0] rspData, // response data
  input wire logic monValid // monitor streaming
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  rsv_bits_zero_a:
    assert property ((rxWord & 16'hF15E) == 16'h0000)
    else $error("reserved status bit set");
  rsp_timing_a:
    assert property (rspValid == $past(cmdValid))
    else $error("response not one cycle after command");
  cmd_spacing_a:
    assert property (cmdValid |=> !cmdValid ##1 !cmdValid)
    else $error("command issued before response");
  refused_data_a:
    assert property (rspValid && rspErr |-> rspData == 16'h0000)
    else $error("refused response carries data");
  init_follow_a:
    assert property (ryWord[9] |=> rxWord[9])
    else $error("init done did not follow request");
  init_clear_a:
    assert property (!ryWord[9] |=> !rxWord[9])
    else $error("init done stayed after request off");
  disp_clear_a:
    assert property (!ryWord[0] |=> !rxWord[0])
    else $error("display done without request");
  err_cause_a:
    assert property ($rose(rxWord[10]) |-> $past(cmdValid && cmdSys))
    else $error("error flag without system command");
  err_reset_a:
    assert property (ryWord[10] && !cmdValid |=> !rxWord[10])
    else $error("error flag survived reset request");
  touch_pair_a:
    assert property (rxWord[5] == rxWord[7])
    else $error("touch and tag flags differ");
  touch_clear_a:
    assert property ($fell(rxWord[5]) |->
      $past(cmdValid && !cmdWrite && cmdSys && cmdAddr == TAG_WORD))
    else $error("touch flag cleared without tag read");
  mon_cause_a:
    assert property (monValid |-> $past(ryWord[1]))
    else $error("monitor stream without request");
  // ----------------------------------------------------------------
  // Coverage
  // ----------------------------------------------------------------
  cover property (rspValid && rspErr);
  cover property ($fell(rxWord[5]));
  cover property ($fell(rxWord[10]));
  cover property (monValid);
endmodule

// [dv/rsh_tb.sv]
// Bench joining both link ends and checking them through their user sides and the link signals.
`timescale 1ns/1ps
`define CHK(nm, exp, act) begin \
  num_checks++; \
  if ((act) !== (exp)) begin \
    n_errors++; \
    $display("[FAIL] %s exp %0h got %0h", nm, exp, act); \
  end \
end
module rsh_tb
  import rsh_pkg::*;
;
  logic clk;
  logic rst;
  logic [5:0] stationNo;
  logic [2:0] occNodes;
  logic cmdMode;
  logic [10:0] systemAreaBase;
  logic [2:0] linkSpeed;
  logic online;
  logic linkDone;
  logic initLoading;
  logic procDone;
  logic tagWrite;
  logic [15:0] tagData;
  logic [USER_BITS-1:0] rxUserIn;
  logic [USER_BITS-1:0] ryUserOut;
  logic [6:0] mBase;
  logic [2:0] nOffset;
  logic [6:0] userPoints;
  logic cfgValid;
  logic [3:0] regAddr;
  logic [15:0] regWdata;
  logic regWr;
  logic regRd;
  logic [15:0] regRdata;
  logic [USER_BITS-1:0] ryUserIn;
  logic [USER_BITS-1:0] rxUserOut;
  logic [15:0] rdv;
  int n_errors;
  int num_checks;

  rsh_link_if rsh_link_if_i ();
  rsh_device rsh_device_i (.clk(clk), .rst(rst), .link(rsh_link_if_i),
    .stationNo(stationNo), .occNodes(occNodes), .cmdMode(cmdMode),
    .systemAreaBase(systemAreaBase), .linkSpeed(linkSpeed),
    .online(online), .linkDone(linkDone), .initLoading(initLoading),
    .procDone(procDone), .tagWrite(tagWrite), .tagData(tagData),
    .rxUserIn(rxUserIn), .ryUserOut(ryUserOut), .mBase(mBase),
    .nOffset(nOffset), .userPoints(userPoints), .cfgValid(cfgValid));
  rsh_master rsh_master_i (.clk(clk), .rst(rst), .link(rsh_link_if_i),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .ryUserIn(ryUserIn), .rxUserOut(rxUserOut));
  rsh_sva rsh_sva_i (.clk(clk), .rst(rst), .ryWord(rsh_link_if_i.ryWord),
    .rxWord(rsh_link_if_i.rxWord), .cmdValid(rsh_link_if_i.cmdValid),
    .cmdWrite(rsh_link_if_i.cmdWrite), .cmdSys(rsh_link_if_i.cmdSys),
    .cmdAddr(rsh_link_if_i.cmdAddr), .rspValid(rsh_link_if_i.rspValid),
    .rspErr(rsh_link_if_i.rspErr), .rspData(rsh_link_if_i.rspData),
    .monValid(rsh_link_if_i.monValid));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Bus and helper tasks
  // ----------------------------------------------------------------
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 rdv = regRdata;
    // Return on an edge so that callers drive their next inputs there.
    @(posedge clk);
  endtask
  // A command always settles three cycles after its strobe; no polling.
  task automatic cmd(input logic s, input logic w, input logic [10:0] a,
    input logic [15:0] d, input logic e, input string nm);
    wr(REG_WDATA, d);
    wr(REG_CMD, {w, s, 3'h0, a});
    idle(3);
    rd(REG_CMDST);
    `CHK(nm, e, rdv[2])
    if (!w && !e) begin
      rd(REG_RESULT);
      `CHK(nm, d, rdv)
    end
  endtask
  task automatic waitrx(input int b, input logic v, input string nm);
    int k;
    k = 0;
    #1;
    while (rsh_link_if_i.rxWord[b] !== v && k < 20) begin
      @(posedge clk);
      #1;
      k++;
    end
    `CHK(nm, v, rsh_link_if_i.rxWord[b])
  endtask
  task automatic cfg(input logic [5:0] st, input logic [2:0] occ);
    stationNo <= st;
    occNodes <= occ;
    wr(REG_CFG, {5'h00, occ, 2'h0, st});
    idle(3);
  endtask
  task automatic results;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_map;
    for (int i = 2; i <= 4; i++) begin
      cfg(6'h05, 3'(i));
      `CHK("mBase", 7'h08, mBase)
      `CHK("nOffset", 3'(2 * i - 1), nOffset)
      `CHK("points", 7'(32 * i - 16), userPoints)
      rd(REG_MAP);
      `CHK("map", {6'h00, 3'(2 * i - 1), 7'h08}, rdv)
    end
    cfg(6'h3E, 3'h4);
    `CHK("cap4", 1'b0, cfgValid)
    cfg(6'h3D, 3'h4);
    `CHK("max4", 1'b1, cfgValid)
    cfg(6'h3F, 3'h2);
    `CHK("max2", 1'b1, cfgValid)
    systemAreaBase <= 11'h013;
    idle(3);
    `CHK("baseLo", 1'b0, cfgValid)
    systemAreaBase <= 11'h7BD;
    idle(3);
    `CHK("baseHi", 1'b0, cfgValid)
    linkSpeed <= 3'h5;
    systemAreaBase <= 11'h7BC;
    idle(3);
    `CHK("speed5", 1'b0, cfgValid)
    for (int s = 0; s <= 4; s++) begin
      linkSpeed <= 3'(s);
      idle(3);
      `CHK("speed", 1'b1, cfgValid)
    end
    systemAreaBase <= 11'h014;
    cfg(6'h05, 3'h2);
  endtask
  task automatic t_ready;
    idle(2);
    rd(REG_STATUS);
    `CHK("ready", 1'b1, rdv[11])
    initLoading <= 1'b1;
    idle(3);
    rd(REG_STATUS);
    `CHK("loading", 1'b0, rdv[11])
    initLoading <= 1'b0;
    online <= 1'b0;
    idle(3);
    rd(REG_STATUS);
    `CHK("offline", 1'b0, rdv[11])
    online <= 1'b1;
  endtask
  task automatic t_ordinary;
    cmd(1'b1, 1'b0, 11'h000, 16'h0000, 1'b1, "ordSys");
    cmd(1'b0, 1'b1, 11'h023, 16'hA5A5, 1'b0, "userWr");
    cmd(1'b0, 1'b0, 11'h023, 16'hA5A5, 1'b0, "userRd");
    cmd(1'b0, 1'b1, 11'h024, 16'h1234, 1'b1, "userOut");
    rd(REG_STATUS);
    `CHK("ordErr", 1'b0, rdv[10])
  endtask
  task automatic t_command;
    cmdMode <= 1'b1;
    cmd(1'b0, 1'b1, 11'h023, 16'h5555, 1'b1, "cmUserWr");
    cmd(1'b0, 1'b0, 11'h023, 16'hA5A5, 1'b0, "cmUserRd");
    cmd(1'b1, 1'b1, 11'h017, 16'h3C3C, 1'b0, "cmSysWr");
    cmd(1'b1, 1'b0, 11'h017, 16'h3C3C, 1'b0, "cmSysRd");
    cmd(1'b1, 1'b0, 11'h018, 16'h0000, 1'b1, "relay");
    rd(REG_STATUS);
    `CHK("errSet", 1'b1, rdv[10])
    `CHK("errWord", 16'h0C00, rdv)
    wr(REG_CTRL, 16'h0400);
    waitrx(10, 1'b0, "errClr");
    wr(REG_CTRL, 16'h0000);
  endtask
  task automatic t_flags;
    wr(REG_CTRL, 16'hF1F8);
    idle(3);
    rd(REG_STATUS);
    `CHK("rsv", 16'h0000, rdv & 16'hF15F)
    rd(REG_CTRL);
    `CHK("ctrlMask", 16'h0000, rdv)
    wr(REG_CTRL, 16'h0001);
    procDone <= 1'b1;
    @(posedge clk);
    procDone <= 1'b0;
    waitrx(0, 1'b1, "dispSet");
    wr(REG_CTRL, 16'h0000);
    waitrx(0, 1'b0, "dispClr");
    wr(REG_CTRL, 16'h0200);
    waitrx(9, 1'b1, "initSet");
    waitrx(9, 1'b0, "initClr");
    rd(REG_CTRL);
    `CHK("initReq", 1'b0, rdv[9])
  endtask
  task automatic t_tag;
    tagData <= 16'h00C3;
    tagWrite <= 1'b1;
    @(posedge clk);
    tagWrite <= 1'b0;
    waitrx(5, 1'b1, "touch");
    waitrx(7, 1'b1, "tagReq");
    cmd(1'b1, 1'b0, TAG_WORD, 16'h00C3, 1'b0, "tagRd");
    waitrx(5, 1'b0, "touchClr");
    wr(REG_AUTO, 16'h0001);
    tagData <= 16'h005A;
    tagWrite <= 1'b1;
    @(posedge clk);
    tagWrite <= 1'b0;
    idle(12);
    rd(REG_TAG);
    `CHK("autoTag", 16'h005A, rdv)
    waitrx(7, 1'b0, "autoClr");
    wr(REG_AUTO, 16'h0000);
  endtask
  task automatic t_user;
    rxUserIn <= '1;
    ryUserIn <= '1;
    idle(4);
    `CHK("rxUser2", {{(USER_BITS-48){1'b0}}, {48{1'b1}}}, rxUserOut)
    `CHK("ryUser2", {{(USER_BITS-48){1'b0}}, {48{1'b1}}}, ryUserOut)
    cfg(6'h05, 3'h4);
    idle(2);
    `CHK("rxUser4", {USER_BITS{1'b1}}, rxUserOut)
    for (int w = 0; w < 4; w++) begin
      cmd(1'b1, 1'b1, 11'(w), 16'h0F0F, 1'b0, "monWr");
    end
    wr(REG_CTRL, 16'h0002);
    idle(6);
    `CHK("monOn", 1'b1, rsh_link_if_i.monValid)
    rd(REG_MON);
    `CHK("monData", 16'h0F0F, rdv)
    wr(REG_CTRL, 16'h0000);
    idle(3);
    `CHK("monOff", 1'b0, rsh_link_if_i.monValid)
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    stationNo = 6'h01;
    occNodes = 3'h2;
    cmdMode = 1'b0;
    systemAreaBase = 11'h014;
    linkSpeed = 3'h4;
    online = 1'b1;
    linkDone = 1'b1;
    initLoading = 1'b0;
    procDone = 1'b0;
    tagWrite = 1'b0;
    tagData = 16'h0000;
    rxUserIn = '0;
    ryUserIn = '0;
    regAddr = 4'h0;
    regWdata = 16'h0000;
    regWr = 1'b0;
    regRd = 1'b0;
    n_errors = 0;
    num_checks = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_map;
    t_ready;
    t_ordinary;
    t_command;
    t_flags;
    t_tag;
    t_user;
    rst <= 1'b1;
    idle(2);
    rst <= 1'b0;
    rd(REG_CFG);
    `CHK("cfgRst", CFG_RESET, rdv)
    results;
  end
  // A hang anywhere ends in the same verdict path.
  initial begin
    #(50 * 20000);
    n_errors++;
    results;
  end
endmodule
